// ---- pkg/ccr_evt_if.sv ----
// Interface carrying one comparator's edge events into the register bank
interface ccr_evt_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// ---- pkg/ccr_pkg.sv ----
// Package of offsets, field positions and reset values for comparator control
package ccr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    // Register offsets
    localparam logic [7:0] OFS_CTRL1 = 8'h9a;
    localparam logic [7:0] OFS_MODE1 = 8'h9c;
    localparam logic [7:0] OFS_MODE0 = 8'h9d;
    localparam logic [7:0] OFS_MUX0  = 8'h9f;
    localparam logic [7:0] OFS_CTRL0 = 8'h9b;
    localparam logic [7:0] OFS_MUX1  = 8'h9e;
    // Control register fields
    localparam int unsigned B_ON     = 7;
    localparam int unsigned B_RESULT = 6;
    localparam int unsigned B_RISE   = 5;
    localparam int unsigned B_FALL   = 4;
    localparam int unsigned B_HYP    = 2;
    localparam int unsigned B_HYN    = 0;
    // Mode register fields
    localparam int unsigned B_RIE    = 5;
    localparam int unsigned B_FIE    = 4;
    localparam int unsigned B_SPEED  = 0;
    // Input select fields
    localparam int unsigned B_MINUS  = 4;
    localparam int unsigned B_PLUS   = 0;
    // Reset values and the read value of unmapped offsets
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [1:0] RST_SPEED = 2'h2;
    localparam logic [7:0] RST_MUX   = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ---- src/ccr_edge.sv ----
// Synchroniser and edge detector for one comparator output
module ccr_edge (
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic raw,
    ccr_evt_if.src    evt
);
    logic s1;
    logic s2;
    logic s3;

    // Two stages before anyone looks at the level; s1 is read only by s2
    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign evt.level = s2;
    assign evt.rise  = s2 & ~s3;
    assign evt.fall  = ~s2 & s3;
endmodule

// ---- src/ccr_flags.sv ----
// Sticky rise and fall flags for one comparator
module ccr_flags (
    input  wire logic CLK,
    input  wire logic RESET,
    ccr_evt_if.dst    evt,
    input  wire logic wr_ctrl,
    input  wire logic wr_rise,
    input  wire logic wr_fall,
    output logic      rise_flag,
    output logic      fall_flag
);
    // Edge set wins over a software clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rise_flag <= 1'b0;
            fall_flag <= 1'b0;
        end else begin
            if (evt.rise) begin
                rise_flag <= 1'b1;
            end else if (wr_ctrl) begin
                rise_flag <= wr_rise;
            end
            if (evt.fall) begin
                fall_flag <= 1'b1;
            end else if (wr_ctrl) begin
                fall_flag <= wr_fall;
            end
        end
    end
endmodule

// ---- src/ccr_top.sv ----
// Control and status register bank for two comparators
// Summary of operation
// - Mode bit 5 enables the rising-edge interrupt request
// - Mode bit 4 enables the falling-edge interrupt request
// - Mode bits 1:0 pick response time, 00 fastest, 11 slowest
// - Mode register resets to speed 10, all other bits zero
// - Unused bits 7:6 and 3:2 read zero, writes ignored
// - Comparator 0 minus select in bits 5:4, four pins
// - Comparator 0 plus select in bits 1:0, four pins
// - Comparator 1 input select has same layout
// - Comparator 1 mode register matches comparator 0 layout and reset
// - Edges set sticky flags until software writes zero
// - Result bit shows live state; enable bit powers comparator
//
// Added by the designer: the strobed register port.
module ccr_top
    import ccr_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       RESET,
    input  wire logic [ccr_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [ccr_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic [ccr_pkg::DATA_W-1:0]      RDATA,
    input  wire logic                       CMP0_RAW,
    input  wire logic                       CMP1_RAW,
    output logic                            CMP0_ON,
    output logic                            CMP1_ON,
    output logic [1:0]                      CMP0_SPEED_SEL,
    output logic [1:0]                      CMP1_SPEED_SEL,
    output logic [1:0]                      CMP0_POS_HYST,
    output logic [1:0]                      CMP0_NEG_HYST,
    output logic [1:0]                      CMP1_POS_HYST,
    output logic [1:0]                      CMP1_NEG_HYST,
    output logic [1:0]                      CMP0_MINUS_SEL,
    output logic [1:0]                      CMP0_PLUS_SEL,
    output logic [1:0]                      CMP1_MINUS_SEL,
    output logic [1:0]                      CMP1_PLUS_SEL,
    output logic                            CMP0_IRQ,
    output logic                            CMP1_IRQ,
    output logic                            IRQ
);
    ccr_evt_if e0 ();
    ccr_evt_if e1 ();

    logic       cmp0_rise_flag;
    logic       cmp0_fall_flag;
    logic       cmp1_rise_flag;
    logic       cmp1_fall_flag;
    logic       cmp0_rise_irq_on;
    logic       cmp0_fall_irq_on;
    logic       cmp1_rise_irq_on;
    logic       cmp1_fall_irq_on;
    logic       wr_ctrl0;
    logic       wr_ctrl1;
    logic [7:0] next_rdata;
    logic       next_irq0;
    logic       next_irq1;

    // Raw analog results cross into the clock domain here
    ccr_edge u_edge0 (.CLK(CLK), .RESET(RESET), .raw(CMP0_RAW), .evt(e0));
    ccr_edge u_edge1 (.CLK(CLK), .RESET(RESET), .raw(CMP1_RAW), .evt(e1));

    assign wr_ctrl0 = WR && (ADDR == OFS_CTRL0);
    assign wr_ctrl1 = WR && (ADDR == OFS_CTRL1);

    // Sticky edge flags
    ccr_flags u_flags0 (
        .CLK       (CLK),
        .RESET     (RESET),
        .evt       (e0),
        .wr_ctrl   (wr_ctrl0),
        .wr_rise   (WDATA[B_RISE]),
        .wr_fall   (WDATA[B_FALL]),
        .rise_flag (cmp0_rise_flag),
        .fall_flag (cmp0_fall_flag)
    );
    ccr_flags u_flags1 (
        .CLK       (CLK),
        .RESET     (RESET),
        .evt       (e1),
        .wr_ctrl   (wr_ctrl1),
        .wr_rise   (WDATA[B_RISE]),
        .wr_fall   (WDATA[B_FALL]),
        .rise_flag (cmp1_rise_flag),
        .fall_flag (cmp1_fall_flag)
    );

    // Control registers: enable and hysteresis
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CMP0_ON       <= RST_CTRL[B_ON];
            CMP0_POS_HYST <= RST_CTRL[B_HYP +: 2];
            CMP0_NEG_HYST <= RST_CTRL[B_HYN +: 2];
            CMP1_ON       <= RST_CTRL[B_ON];
            CMP1_POS_HYST <= RST_CTRL[B_HYP +: 2];
            CMP1_NEG_HYST <= RST_CTRL[B_HYN +: 2];
        end else begin
            if (wr_ctrl0) begin
                CMP0_ON       <= WDATA[B_ON];
                CMP0_POS_HYST <= WDATA[B_HYP +: 2];
                CMP0_NEG_HYST <= WDATA[B_HYN +: 2];
            end
            if (wr_ctrl1) begin
                CMP1_ON       <= WDATA[B_ON];
                CMP1_POS_HYST <= WDATA[B_HYP +: 2];
                CMP1_NEG_HYST <= WDATA[B_HYN +: 2];
            end
        end
    end

    // Mode registers; only the defined fields are stored
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cmp0_rise_irq_on <= 1'b0;
            cmp0_fall_irq_on <= 1'b0;
            CMP0_SPEED_SEL   <= RST_SPEED;
            cmp1_rise_irq_on <= 1'b0;
            cmp1_fall_irq_on <= 1'b0;
            CMP1_SPEED_SEL   <= RST_SPEED;
        end else begin
            if (WR && ADDR == OFS_MODE0) begin
                cmp0_rise_irq_on <= WDATA[B_RIE];
                cmp0_fall_irq_on <= WDATA[B_FIE];
                CMP0_SPEED_SEL   <= WDATA[B_SPEED +: 2];
            end
            if (WR && ADDR == OFS_MODE1) begin
                cmp1_rise_irq_on <= WDATA[B_RIE];
                cmp1_fall_irq_on <= WDATA[B_FIE];
                CMP1_SPEED_SEL   <= WDATA[B_SPEED +: 2];
            end
        end
    end

    // Input multiplexer selects
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CMP0_MINUS_SEL <= RST_MUX[B_MINUS +: 2];
            CMP0_PLUS_SEL  <= RST_MUX[B_PLUS +: 2];
            CMP1_MINUS_SEL <= RST_MUX[B_MINUS +: 2];
            CMP1_PLUS_SEL  <= RST_MUX[B_PLUS +: 2];
        end else begin
            if (WR && ADDR == OFS_MUX0) begin
                CMP0_MINUS_SEL <= WDATA[B_MINUS +: 2];
                CMP0_PLUS_SEL  <= WDATA[B_PLUS +: 2];
            end
            if (WR && ADDR == OFS_MUX1) begin
                CMP1_MINUS_SEL <= WDATA[B_MINUS +: 2];
                CMP1_PLUS_SEL  <= WDATA[B_PLUS +: 2];
            end
        end
    end

    // Read mux; unused bits come back zero
    always_comb begin
        next_rdata = RD_UNMAPPED;
        case (ADDR)
            OFS_CTRL0: next_rdata = {CMP0_ON, e0.level, cmp0_rise_flag, cmp0_fall_flag,
                                     CMP0_POS_HYST, CMP0_NEG_HYST};
            OFS_CTRL1: next_rdata = {CMP1_ON, e1.level, cmp1_rise_flag, cmp1_fall_flag,
                                     CMP1_POS_HYST, CMP1_NEG_HYST};
            OFS_MODE0: next_rdata = {2'h0, cmp0_rise_irq_on, cmp0_fall_irq_on,
                                     2'h0, CMP0_SPEED_SEL};
            OFS_MODE1: next_rdata = {2'h0, cmp1_rise_irq_on, cmp1_fall_irq_on,
                                     2'h0, CMP1_SPEED_SEL};
            OFS_MUX0:  next_rdata = {2'h0, CMP0_MINUS_SEL, 2'h0, CMP0_PLUS_SEL};
            OFS_MUX1:  next_rdata = {2'h0, CMP1_MINUS_SEL, 2'h0, CMP1_PLUS_SEL};
            default:   next_rdata = RD_UNMAPPED;
        endcase
    end

    // Read data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? next_rdata : 8'h00;
        end
    end

    // Flag and enable pairs form each comparator's request
    assign next_irq0 = (cmp0_rise_flag & cmp0_rise_irq_on) | (cmp0_fall_flag & cmp0_fall_irq_on);
    assign next_irq1 = (cmp1_rise_flag & cmp1_rise_irq_on) | (cmp1_fall_flag & cmp1_fall_irq_on);

    // Registered so every output leaves a flip-flop; costs one cycle of latency
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CMP0_IRQ <= 1'b0;
            CMP1_IRQ <= 1'b0;
            IRQ      <= 1'b0;
        end else begin
            CMP0_IRQ <= next_irq0;
            CMP1_IRQ <= next_irq1;
            IRQ      <= next_irq0 | next_irq1;
        end
    end

    // Assertions
    property p_rise_irq;
        @(posedge CLK) disable iff (RESET)
        (cmp0_rise_flag && cmp0_rise_irq_on) |=> CMP0_IRQ;
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("rise irq missing");

    property p_fall_irq;
        @(posedge CLK) disable iff (RESET)
        (cmp1_fall_flag && cmp1_fall_irq_on) |=> CMP1_IRQ;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("fall irq missing");

    property p_speed;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == OFS_MODE0) |=> (CMP0_SPEED_SEL == $past(WDATA[1:0]));
    endproperty
    a_speed: assert property (p_speed) else $error("speed not stored");

    property p_reset_mode;
        @(posedge CLK) $fell(RESET) |-> (CMP0_SPEED_SEL == 2'h2 && CMP1_SPEED_SEL == 2'h2
                                         && !cmp0_rise_irq_on && !cmp1_fall_irq_on);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("bad mode reset");

    property p_unused_zero;
        @(posedge CLK) disable iff (RESET)
        (RD && (ADDR == OFS_MODE0 || ADDR == OFS_MUX0 || ADDR == OFS_MUX1))
            |=> (RDATA[7:6] == 2'h0 && RDATA[3:2] == 2'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    property p_mux_minus;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == OFS_MUX0) |=> (CMP0_MINUS_SEL == $past(WDATA[5:4]));
    endproperty
    a_mux_minus: assert property (p_mux_minus) else $error("minus select wrong");

    property p_set_wins;
        @(posedge CLK) disable iff (RESET)
        (e0.rise && wr_ctrl0) |=> cmp0_rise_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("edge lost on clear");

    property p_sticky;
        @(posedge CLK) disable iff (RESET)
        (cmp1_fall_flag && !wr_ctrl1) |=> cmp1_fall_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_irq_quiet;
        @(posedge CLK) disable iff (RESET)
        (!next_irq0 && !next_irq1) |=> !IRQ;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("spurious irq");

    property p_unused1;
        @(posedge CLK) disable iff (RESET)
        (RD && ADDR == OFS_MODE1) |=> (RDATA[7:6] == 2'h0 && RDATA[3:2] == 2'h0);
    endproperty
    a_unused1: assert property (p_unused1) else $error("unused bits set");

    property p_mux_plus;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == OFS_MUX0) |=> (CMP0_PLUS_SEL == $past(WDATA[1:0]));
    endproperty
    a_mux_plus: assert property (p_mux_plus) else $error("plus select wrong");

    property p_mux1;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == OFS_MUX1)
            |=> (CMP1_MINUS_SEL == $past(WDATA[5:4]) && CMP1_PLUS_SEL == $past(WDATA[1:0]));
    endproperty
    a_mux1: assert property (p_mux1) else $error("select 1 wrong");

    property p_mode1;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == OFS_MODE1)
            |=> (CMP1_SPEED_SEL == $past(WDATA[1:0]) && cmp1_rise_irq_on == $past(WDATA[5]));
    endproperty
    a_mode1: assert property (p_mode1) else $error("mode 1 not stored");

    property p_ctrl_store;
        @(posedge CLK) disable iff (RESET)
        wr_ctrl1 |=> (CMP1_POS_HYST == $past(WDATA[3:2]) && CMP1_NEG_HYST == $past(WDATA[1:0]));
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("hysteresis not stored");

    property p_enable;
        @(posedge CLK) disable iff (RESET)
        wr_ctrl0 |=> (CMP0_ON == $past(WDATA[7]));
    endproperty
    a_enable: assert property (p_enable) else $error("enable not stored");

    property p_result_live;
        @(posedge CLK) disable iff (RESET)
        (RD && ADDR == OFS_CTRL0) |=> (RDATA[6] == $past(e0.level));
    endproperty
    a_result_live: assert property (p_result_live) else $error("result bit stale");

    property p_rise_sets;
        @(posedge CLK) disable iff (RESET)
        e0.rise |=> cmp0_rise_flag;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

    property p_fall_sets;
        @(posedge CLK) disable iff (RESET)
        e1.fall |=> cmp1_fall_flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

    c_rise: cover property (@(posedge CLK) disable iff (RESET) e0.rise ##[1:4] CMP0_IRQ);
    c_fall: cover property (@(posedge CLK) disable iff (RESET) e1.fall);
    c_clash: cover property (@(posedge CLK) disable iff (RESET) e0.rise && wr_ctrl0);
endmodule

// ---- verif/ccr_top_tb.sv ----
// Self-checking testbench for the comparator control register bank
module ccr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ccr_pkg::*;

    // Address tables so both comparators share one test loop
    localparam logic [7:0] A_CTL [2] = '{OFS_CTRL0, OFS_CTRL1};
    localparam logic [7:0] A_MOD [2] = '{OFS_MODE0, OFS_MODE1};
    localparam logic [7:0] A_MUX [2] = '{OFS_MUX0, OFS_MUX1};

    logic       clk;
    logic       reset;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [1:0] raw;
    logic [1:0] on;
    logic [1:0] cirq;
    logic       irq;
    logic [1:0] spd   [2];
    logic [1:0] phy   [2];
    logic [1:0] nhy   [2];
    logic [1:0] minus [2];
    logic [1:0] plus  [2];
    int         fail_count;
    int         tests_run;
    int         n;
    int         c;

    ccr_top ccr_top_inst (
        .CLK            (clk),
        .RESET          (reset),
        .ADDR           (addr),
        .WDATA          (wdata),
        .WR             (wr_s),
        .RD             (rd_s),
        .RDATA          (rdata),
        .CMP0_RAW       (raw[0]),
        .CMP1_RAW       (raw[1]),
        .CMP0_ON        (on[0]),
        .CMP1_ON        (on[1]),
        .CMP0_SPEED_SEL (spd[0]),
        .CMP1_SPEED_SEL (spd[1]),
        .CMP0_POS_HYST  (phy[0]),
        .CMP0_NEG_HYST  (nhy[0]),
        .CMP1_POS_HYST  (phy[1]),
        .CMP1_NEG_HYST  (nhy[1]),
        .CMP0_MINUS_SEL (minus[0]),
        .CMP0_PLUS_SEL  (plus[0]),
        .CMP1_MINUS_SEL (minus[1]),
        .CMP1_PLUS_SEL  (plus[1]),
        .CMP0_IRQ       (cirq[0]),
        .CMP1_IRQ       (cirq[1]),
        .IRQ            (irq)
    );

    // 100 MHz system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Case equality so an unknown never counts as a match
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write, then an idle edge so no strobe is assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe; taken mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    // Let edges pass through the two-stage synchroniser
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #20us;
        fail_count++;
        final_report();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        tests_run  = 0;
        reset <= 1'b1;
        wr_s  <= 1'b0;
        rd_s  <= 1'b0;
        addr  <= 8'h00;
        wdata <= 8'h00;
        raw   <= 2'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        // Unmapped place: write ignored, reads zero
        wr(8'h00, 8'hff);
        rd(8'h00, got);
        chk(got, RD_UNMAPPED);
        // Read data must fall back to zero once their cycle is over
        rd(A_MOD[0], got);
        chk(got, {6'h0, RST_SPEED});
        @(negedge clk);
        chk(rdata, 8'h00);
        @(posedge clk);
        for (n = 0; n < 2; n++) begin
            chk({6'h0, spd[n]}, {6'h0, RST_SPEED});
            rd(A_CTL[n], got);
            chk(got, RST_CTRL);
            rd(A_MOD[n], got);
            chk(got, {6'h0, RST_SPEED});
            rd(A_MUX[n], got);
            chk(got, RST_MUX);
            // Unused pairs must stay zero whatever is written
            wr(A_MOD[n], 8'hff);
            rd(A_MOD[n], got);
            chk(got, 8'h33);
            wr(A_MUX[n], 8'hff);
            rd(A_MUX[n], got);
            chk(got, 8'h33);
            // Every speed code and every pin code, back to back
            for (c = 0; c < 4; c++) begin
                wr(A_MOD[n], {6'h0, c[1:0]});
                chk({6'h0, spd[n]}, {6'h0, c[1:0]});
                wr(A_MUX[n], {2'h0, c[1:0], 2'h0, ~c[1:0]});
                chk({4'h0, minus[n], plus[n]}, {4'h0, c[1:0], ~c[1:0]});
            end
            // Bit 6 written high must not stick
            wr(A_CTL[n], 8'hc9);
            rd(A_CTL[n], got);
            chk(got, 8'h89);
            chk({3'h0, on[n], phy[n], nhy[n]}, 8'h19);
            // Rising edge with only the rising request enabled
            wr(A_MOD[n], 8'h20);
            wr(A_CTL[n], 8'h89);
            raw[n] <= 1'b1;
            settle(8);
            rd(A_CTL[n], got);
            chk(got, 8'he9);
            chk({6'h0, cirq[n], irq}, 8'h03);
            wr(A_MOD[n], 8'h00);
            settle(2);
            chk({6'h0, cirq[n], irq}, 8'h00);
            // Falling edge; rising flag must still be held
            raw[n] <= 1'b0;
            settle(8);
            rd(A_CTL[n], got);
            chk(got, 8'hb9);
            wr(A_MOD[n], 8'h10);
            settle(2);
            chk({6'h0, cirq[n], irq}, 8'h03);
            // Clear the flags one at a time
            wr(A_CTL[n], 8'h99);
            rd(A_CTL[n], got);
            chk(got, 8'h99);
            settle(2);
            chk({6'h0, cirq[n], irq}, 8'h03);
            wr(A_CTL[n], 8'h89);
            settle(2);
            chk({6'h0, cirq[n], irq}, 8'h00);
            rd(A_CTL[n], got);
            chk(got, 8'h89);
            wr(A_CTL[n], 8'h00);
            chk({7'h0, on[n]}, 8'h00);
            // New rise lands in the very cycle that software clears the flag
            raw[n] <= 1'b1;
            settle(2);
            wr(A_CTL[n], 8'h00);
            rd(A_CTL[n], got);
            chk(got, 8'h60);
            raw[n] <= 1'b0;
            settle(8);
            wr(A_CTL[n], 8'h00);
            rd(A_CTL[n], got);
            chk(got, 8'h00);
        end
        // Second reset in mid-run brings the mode register back
        reset <= 1'b1;
        settle(2);
        reset <= 1'b0;
        settle(1);
        rd(A_MOD[1], got);
        chk(got, {6'h0, RST_SPEED});
        final_report();
    end
endmodule
